/* sfpe_pkg.sv */
// Shared constants and types for the serial flash program and erase sequencer.
// Assumes a 100 MHz system clock and a host-driven serial clock sampled by it.
package sfpe_pkg;

  // Command opcodes as they arrive on the first data line.
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_WRITE = 8'h32;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_TABLE_READ = 8'h5a;

  // Frame lengths in rising serial clock edges.
  localparam logic [5:0] OPCODE_EDGES = 6'h08;
  localparam logic [5:0] HEADER_EDGES = 6'h20;
  localparam logic [5:0] STATUS_FRAME_EDGES = 6'h10;
  localparam logic [5:0] TABLE_FIRST_OUT_EDGE = 6'h28;
  localparam logic [5:0] EDGE_COUNT_MAX = 6'h3f;

  // Page geometry and the value that an erased byte reads as.
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Self-timed cycle times in microseconds, and the clock rate in MHz.
  localparam int CLOCK_MHZ = 100;
  localparam int PAGE_PROGRAM_TIME_US = 100;
  localparam int SUBSECTOR_ERASE_TIME_US = 500;
  localparam int SECTOR_ERASE_TIME_US = 1000;
  localparam int BULK_ERASE_TIME_US = 4000;
  localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int SUBSECTOR_ERASE_CYCLES = SUBSECTOR_ERASE_TIME_US * CLOCK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLOCK_MHZ;
  localparam int BULK_ERASE_CYCLES = BULK_ERASE_TIME_US * CLOCK_MHZ;

  // Sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_ERASE = 3'b100
  } sfpe_state_e;

  // Operations that the sequencer asks of the memory array.
  typedef enum logic [2:0]
  {
    ARR_NONE = 3'h0,
    ARR_WRITE_BYTE = 3'h1,
    ARR_ERASE_SUBSECTOR = 3'h2,
    ARR_ERASE_SECTOR = 3'h3,
    ARR_ERASE_ALL = 3'h4
  } sfpe_array_op_e;

  // One request to the memory array.
  typedef struct packed
  {
    logic valid;
    sfpe_array_op_e op;
    logic [23:0] address;
    logic [7:0] data;
  } sfpe_array_req_s;

  // Status bits that the sequencer owns.
  typedef struct packed
  {
    logic write_in_progress;
    logic write_enable_latch;
  } sfpe_status_s;

  // Host-side pins as they arrive, before synchronisation.
  typedef struct packed
  {
    logic chip_select_n;
    logic serial_clock;
    logic [3:0] serial_io;
  } sfpe_pins_s;

endpackage

/* sfpe_sequencer.sv */
// Program, erase and write-protection sequencer of a serial flash device.
// Assumes the host pins are asynchronous to i_clock and that the memory array and the
// parameter table sit outside, on i_clock, answering within one cycle.
`timescale 1ns/1ps

module sfpe_sequencer
#(
  parameter int PAGE_PROGRAM_CYCLES = sfpe_pkg::PAGE_PROGRAM_CYCLES,
  parameter int SUBSECTOR_ERASE_CYCLES = sfpe_pkg::SUBSECTOR_ERASE_CYCLES,
  parameter int SECTOR_ERASE_CYCLES = sfpe_pkg::SECTOR_ERASE_CYCLES,
  parameter int BULK_ERASE_CYCLES = sfpe_pkg::BULK_ERASE_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire sfpe_pkg::sfpe_pins_s i_pins,
  input wire logic [7:0] i_table_byte,
  output logic o_serial_io1,
  output logic o_serial_io1_oe_n,
  output logic [7:0] o_table_index,
  output sfpe_pkg::sfpe_array_req_s o_array_req,
  output sfpe_pkg::sfpe_status_s o_status,
  output logic o_active
);
  import sfpe_pkg::*;

  // Two-stage synchronisers for every host pin, plus a third stage for edges.
  sfpe_pins_s pins_meta_ff; // First stage, read only by the second.
  sfpe_pins_s pins_sync_ff; // Second stage, safe to use.
  logic clock_prev_ff; // Delayed serial clock for edge finding.
  logic select_prev_ff; // Delayed chip select for edge finding.
  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic selected;

  // Frame decoding state.
  logic [5:0] edge_cnt_ff; // Rising edges seen in this frame, saturating.
  logic [7:0] opcode_ff; // Opcode shift register.
  logic [23:0] address_ff; // Address shift register.
  logic [7:0] data_sr_ff; // Data shift register.
  logic [2:0] data_bit_ff; // Bit or nibble position within a data byte.
  logic [7:0] column_ff; // Page column of the next data byte.
  logic data_seen_ff; // At least one whole data byte arrived.
  logic frame_ok_ff; // The frame was opened while idle, so it may act.
  logic header_done;
  logic is_quad;
  logic is_program_op;

  // Page buffer, one entry per column.
  logic [7:0] page_data_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_ff;
  logic page_clear;
  logic page_we;
  logic [7:0] page_byte;

  // Sequencer state.
  sfpe_state_e state_ff;
  logic [31:0] timer_ff; // Cycles left in the self-timed cycle.
  logic [8:0] walk_ff; // Page column being handed to the array.
  logic wel_ff; // Write enable latch.
  logic start_program;
  logic start_erase;
  sfpe_array_op_e erase_op;
  logic [31:0] erase_cycles;
  logic busy;

  // Table read state.
  logic reading_ff; // Table contents are being shifted out.
  logic [2:0] out_bit_ff; // Bit of the current table byte to drive next.

  // Pins cross from the host domain through two flip-flops before any use.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      pins_meta_ff <= '{chip_select_n: 1'b1, serial_clock: 1'b0, serial_io: 4'h0};
      pins_sync_ff <= '{chip_select_n: 1'b1, serial_clock: 1'b0, serial_io: 4'h0};
      clock_prev_ff <= 1'b0;
      select_prev_ff <= 1'b1;
    end
    else if (i_enable)
    begin
      pins_meta_ff <= i_pins;
      pins_sync_ff <= pins_meta_ff;
      clock_prev_ff <= pins_sync_ff.serial_clock;
      select_prev_ff <= pins_sync_ff.chip_select_n;
    end
  end

  // Edges are taken between the second and third stages, so data and clock stay aligned.
  assign selected = ~pins_sync_ff.chip_select_n;
  assign sclk_rise = selected & pins_sync_ff.serial_clock & ~clock_prev_ff;
  assign sclk_fall = selected & ~pins_sync_ff.serial_clock & clock_prev_ff;
  assign frame_end = pins_sync_ff.chip_select_n & ~select_prev_ff;
  assign busy = (state_ff != ST_IDLE);
  assign header_done = (edge_cnt_ff >= HEADER_EDGES);
  assign is_quad = (opcode_ff == OP_QUAD_WRITE);
  assign is_program_op = (opcode_ff == OP_PAGE_WRITE) || is_quad;

  // Opcode, address and edge count are shifted in on rising serial clock edges.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      edge_cnt_ff <= 6'h00;
      opcode_ff <= 8'h00;
      address_ff <= 24'h000000;
      frame_ok_ff <= 1'b0;
    end
    else if (i_enable)
    begin
      if (!selected)
      begin
        // Between frames the counter rests, ready for the next opcode.
        edge_cnt_ff <= 6'h00;
        frame_ok_ff <= ~busy;
      end
      else if (sclk_rise)
      begin
        if (edge_cnt_ff != EDGE_COUNT_MAX)
        begin
          edge_cnt_ff <= edge_cnt_ff + 6'h01;
        end
        if (edge_cnt_ff < OPCODE_EDGES)
        begin
          opcode_ff <= {opcode_ff[6:0], pins_sync_ff.serial_io[0]};
        end
        else if (!header_done)
        begin
          address_ff <= {address_ff[22:0], pins_sync_ff.serial_io[0]};
        end
      end
    end
  end

  // Data bytes are assembled one bit at a time, or a nibble at a time for quad writes.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      data_sr_ff <= 8'h00;
      data_bit_ff <= 3'h0;
      column_ff <= 8'h00;
      data_seen_ff <= 1'b0;
    end
    else if (i_enable)
    begin
      if (!selected)
      begin
        data_bit_ff <= 3'h0;
        data_seen_ff <= 1'b0;
      end
      else if (sclk_rise && (edge_cnt_ff == HEADER_EDGES - 6'h01))
      begin
        // The last address bit fixes the first column.
        column_ff <= {address_ff[6:0], pins_sync_ff.serial_io[0]};
      end
      else if (sclk_rise && header_done && is_program_op)
      begin
        if (is_quad)
        begin
          data_sr_ff <= {data_sr_ff[3:0], pins_sync_ff.serial_io};
          data_bit_ff <= {2'b00, ~data_bit_ff[0]};
        end
        else
        begin
          data_sr_ff <= {data_sr_ff[6:0], pins_sync_ff.serial_io[0]};
          data_bit_ff <= data_bit_ff + 3'h1;
        end
        if (page_we)
        begin
          // The column wraps inside the page and never carries into the page address.
          column_ff <= column_ff + 8'h01;
          data_seen_ff <= 1'b1;
        end
      end
    end
  end

  // A byte is complete on its eighth bit, or on its second nibble.
  always_comb
  begin
    page_we = 1'b0;
    page_byte = {data_sr_ff[6:0], pins_sync_ff.serial_io[0]};
    if (sclk_rise && header_done && is_program_op && frame_ok_ff && wel_ff)
    begin
      if (is_quad)
      begin
        page_we = data_bit_ff[0];
        page_byte = {data_sr_ff[3:0], pins_sync_ff.serial_io};
      end
      else
      begin
        page_we = (data_bit_ff == 3'h7);
      end
    end
  end

  // The buffer is emptied when a new write command is recognised.
  assign page_clear = sclk_rise && (edge_cnt_ff == HEADER_EDGES - 6'h01) && is_program_op &&
    frame_ok_ff && wel_ff;

  // Each page entry keeps the latest byte for its column; later bytes overwrite earlier ones.
  for (genvar g = 0; g < PAGE_BYTES; g++)
  begin : g_page
    always_ff @(posedge i_clock or posedge i_reset)
    begin
      if (i_reset)
      begin
        page_data_ff[g] <= 8'h00;
        page_valid_ff[g] <= 1'b0;
      end
      else if (i_enable)
      begin
        if (page_clear)
        begin
          page_valid_ff[g] <= 1'b0;
        end
        else if (page_we && (column_ff == 8'(g)))
        begin
          page_data_ff[g] <= page_byte;
          page_valid_ff[g] <= 1'b1;
        end
      end
    end
  end

  // Commands take effect when chip select rises; busy cycles lock everything out.
  assign start_program = frame_end && frame_ok_ff && wel_ff && is_program_op &&
    data_seen_ff;
  always_comb
  begin
    start_erase = 1'b0;
    erase_op = ARR_NONE;
    erase_cycles = 32'(BULK_ERASE_CYCLES);
    if (frame_end && frame_ok_ff && wel_ff)
    begin
      if ((opcode_ff == OP_BULK_ERASE) && (edge_cnt_ff == OPCODE_EDGES))
      begin
        start_erase = 1'b1;
        erase_op = ARR_ERASE_ALL;
      end
      else if ((opcode_ff == OP_SECTOR_ERASE) && (edge_cnt_ff == HEADER_EDGES))
      begin
        start_erase = 1'b1;
        erase_op = ARR_ERASE_SECTOR;
        erase_cycles = 32'(SECTOR_ERASE_CYCLES);
      end
      else if ((opcode_ff == OP_SUBSECTOR_ERASE) && (edge_cnt_ff == HEADER_EDGES))
      begin
        start_erase = 1'b1;
        erase_op = ARR_ERASE_SUBSECTOR;
        erase_cycles = 32'(SUBSECTOR_ERASE_CYCLES);
      end
    end
  end

  // Write enable latch: set and cleared by command, cleared as each write cycle starts.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      wel_ff <= 1'b0;
    end
    else if (i_enable && frame_end && frame_ok_ff)
    begin
      if ((opcode_ff == OP_WRITE_ENABLE) && (edge_cnt_ff == OPCODE_EDGES))
      begin
        wel_ff <= 1'b1;
      end
      else if ((opcode_ff == OP_WRITE_DISABLE) && (edge_cnt_ff == OPCODE_EDGES))
      begin
        wel_ff <= 1'b0;
      end
      else if ((opcode_ff == OP_WRITE_STATUS) && (edge_cnt_ff == STATUS_FRAME_EDGES) && wel_ff)
      begin
        wel_ff <= 1'b0;
      end
      else if (start_program || start_erase)
      begin
        // Cleared at the start so it is surely low before the cycle completes.
        wel_ff <= 1'b0;
      end
    end
  end

  // Self-timed cycles: the program cycle also walks the page buffer into the array.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_ff <= ST_IDLE;
      timer_ff <= 32'h00000000;
      walk_ff <= 9'h000;
      o_array_req <= '{valid: 1'b0, op: ARR_NONE, address: 24'h000000, data: 8'h00};
    end
    else if (i_enable)
    begin
      o_array_req.valid <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (start_program)
          begin
            state_ff <= ST_PROGRAM;
            timer_ff <= 32'(PAGE_PROGRAM_CYCLES - 1);
            walk_ff <= 9'h000;
          end
          else if (start_erase)
          begin
            state_ff <= ST_ERASE;
            timer_ff <= erase_cycles - 32'h00000001;
            o_array_req <= '{valid: 1'b1, op: erase_op, address: address_ff, data: ERASED_BYTE};
          end
        end
        ST_PROGRAM:
        begin
          // Only columns that received data are written; the rest stay as they were.
          if (!walk_ff[8])
          begin
            walk_ff <= walk_ff + 9'h001;
            if (page_valid_ff[walk_ff[7:0]])
            begin
              o_array_req <= '{valid: 1'b1, op: ARR_WRITE_BYTE,
                address: {address_ff[23:8], walk_ff[7:0]}, data: page_data_ff[walk_ff[7:0]]};
            end
          end
          if (timer_ff == 32'h00000000)
          begin
            state_ff <= ST_IDLE;
          end
          else
          begin
            timer_ff <= timer_ff - 32'h00000001;
          end
        end
        ST_ERASE:
        begin
          if (timer_ff == 32'h00000000)
          begin
            state_ff <= ST_IDLE;
          end
          else
          begin
            timer_ff <= timer_ff - 32'h00000001;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Table read: shifted out on falling edges once the fortieth rising edge has passed.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      reading_ff <= 1'b0;
      out_bit_ff <= 3'h7;
      o_table_index <= 8'h00;
      o_serial_io1 <= 1'b0;
      o_serial_io1_oe_n <= 1'b1;
    end
    else if (i_enable)
    begin
      if (!selected)
      begin
        reading_ff <= 1'b0;
        out_bit_ff <= 3'h7;
        o_serial_io1_oe_n <= 1'b1;
      end
      else if (sclk_rise && (edge_cnt_ff == HEADER_EDGES - 6'h01))
      begin
        o_table_index <= {address_ff[6:0], pins_sync_ff.serial_io[0]};
      end
      else if (sclk_rise && (edge_cnt_ff == TABLE_FIRST_OUT_EDGE - 6'h01))
      begin
        // A read that arrives during a busy cycle never starts.
        reading_ff <= (opcode_ff == OP_TABLE_READ) && frame_ok_ff;
      end
      else if (sclk_fall && reading_ff)
      begin
        o_serial_io1 <= i_table_byte[out_bit_ff];
        o_serial_io1_oe_n <= 1'b0;
        out_bit_ff <= out_bit_ff - 3'h1;
        if (out_bit_ff == 3'h0)
        begin
          o_table_index <= o_table_index + 8'h01;
        end
      end
    end
  end

  // Status and power mode follow the cycle state and the chip select.
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_status <= '{write_in_progress: 1'b0, write_enable_latch: 1'b0};
      o_active <= 1'b0;
    end
    else if (i_enable)
    begin
      o_status.write_in_progress <= busy;
      o_status.write_enable_latch <= wel_ff;
      // The frame end bridges the one cycle between select rising and the cycle starting.
      o_active <= selected | busy | frame_end;
    end
  end

endmodule

/* sfpe_chk.sv */
// Assertion checker for the flash program and erase sequencer.
// Assumes it is bound to sfpe_sequencer and sees only that module's ports.
`timescale 1ns/1ps
module sfpe_chk
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire sfpe_pkg::sfpe_pins_s i_pins,
  input wire logic [7:0] i_table_byte,
  input wire logic o_serial_io1,
  input wire logic o_serial_io1_oe_n,
  input wire logic [7:0] o_table_index,
  input wire sfpe_pkg::sfpe_array_req_s o_array_req,
  input wire sfpe_pkg::sfpe_status_s o_status,
  input wire logic o_active
);
  import sfpe_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Short names for the status bits and the request kinds.
  wire logic wip = o_status.write_in_progress;
  wire logic wel = o_status.write_enable_latch;
  wire logic wr_req = o_array_req.valid && (o_array_req.op == ARR_WRITE_BYTE);
  wire logic er_req = o_array_req.valid && (o_array_req.op != ARR_WRITE_BYTE);
  // Select must be steady for the synchroniser delay before it counts.
  sequence s_selected;
    (!i_pins.chip_select_n)[*6];
  endsequence
  sequence s_deselected;
    i_pins.chip_select_n[*5];
  endsequence
  sequence s_write_pair;
    wr_req ##1 wr_req;
  endsequence
  property p_erase_ones;
    er_req |-> o_array_req.data == ERASED_BYTE;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase data not all ones");
  property p_erase_pulse;
    er_req |=> !o_array_req.valid && wip;
  endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase request shape");
  property p_req_busy;
    o_array_req.valid |-> ##[0:1] wip;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("array request while idle");
  property p_wip_clears_wel;
    $rose(wip) |-> !wel;
  endproperty
  a_wip_clears_wel: assert property (p_wip_clears_wel) else $error("latch kept in cycle");
  property p_wip_needs_wel;
    $rose(wip) |-> $past(wel) || $past(wel, 2) || $past(wel, 3);
  endproperty
  a_wip_needs_wel: assert property (p_wip_needs_wel) else $error("cycle without latch");
  property p_wel_idle;
    $rose(wel) |-> !wip;
  endproperty
  a_wel_idle: assert property (p_wel_idle) else $error("latch set while busy");
  property p_active_busy;
    wip |-> o_active;
  endproperty
  a_active_busy: assert property (p_active_busy) else $error("standby while busy");
  property p_active_sel;
    s_selected |-> o_active;
  endproperty
  a_active_sel: assert property (p_active_sel) else $error("standby while selected");
  property p_standby;
    (i_pins.chip_select_n && !wip)[*8] |-> !o_active;
  endproperty
  a_standby: assert property (p_standby) else $error("active while idle");
  property p_oe_idle;
    s_deselected |-> o_serial_io1_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("io1 driven while deselected");
  property p_page_order;
    s_write_pair |-> (o_array_req.address[23:8] == $past(o_array_req.address[23:8]))
      && (o_array_req.address[7:0] > $past(o_array_req.address[7:0]));
  endproperty
  a_page_order: assert property (p_page_order) else $error("write left page");
  property p_active_gap;
    $rose(wip) |-> o_active && $past(o_active);
  endproperty
  a_active_gap: assert property (p_active_gap) else $error("standby gap at cycle start");
  property p_table_msb;
    $fell(o_serial_io1_oe_n) |-> o_serial_io1 == $past(i_table_byte[7]);
  endproperty
  a_table_msb: assert property (p_table_msb) else $error("table byte not msb first");
endmodule

bind sfpe_sequencer sfpe_chk chk (.i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
  .i_pins(i_pins), .i_table_byte(i_table_byte), .o_serial_io1(o_serial_io1),
  .o_serial_io1_oe_n(o_serial_io1_oe_n), .o_table_index(o_table_index),
  .o_array_req(o_array_req), .o_status(o_status), .o_active(o_active));

/* sfpe_host.sv */
// Host controller model: drives select, serial clock and the four data lines.
// Assumes a 100 MHz bench clock; one serial clock period is 16 of its cycles.
`timescale 1ns/1ps
module sfpe_host
(
  input wire logic i_clock,
  input wire logic i_io1,
  input wire logic i_io1_oe_n,
  output sfpe_pkg::sfpe_pins_s o_pins
);
  import sfpe_pkg::*;
  logic cs_n = 1'b1; // Select idles high.
  logic sclk = 1'b0; // The serial clock stands low between frames.
  logic [3:0] io = 4'hf; // Host drive of the data lines.
  // The io1 wire carries the device value whenever the device enables it.
  assign o_pins = {cs_n, sclk, io[3:2], (i_io1_oe_n ? io[1] : i_io1), io[0]};
  // Changes land 1 ns after an edge so no race with the sampling edge.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // One serial period: data set while low, taken by the device on the rise.
  task automatic tick(input logic [3:0] v, output logic s);
    io = v;
    wait_cyc(8);
    s = o_pins.serial_io[1];
    sclk = 1'b1;
    wait_cyc(8);
    sclk = 1'b0;
  endtask
  // A frame: the last nq bytes go out as nibbles, then nrd bytes are read.
  task automatic frame(input logic [7:0] q[$], input int nq, input int nrd,
    output logic [7:0] rd[$]);
    logic s;
    logic [7:0] b;
    rd = {};
    cs_n = 1'b0;
    wait_cyc(8);
    foreach (q[i])
    begin
      if (i >= q.size() - nq)
      begin
        tick(q[i][7:4], s);
        tick(q[i][3:0], s);
      end
      else
        for (int k = 7; k >= 0; k--)
          tick({3'b111, q[i][k]}, s);
    end
    for (int j = 0; j < nrd; j++)
    begin
      for (int k = 0; k < 8; k++)
      begin
        tick(4'hf, s);
        b = {b[6:0], s};
      end
      rd.push_back(b);
    end
    wait_cyc(8);
    cs_n = 1'b1;
    io = ~io; // Released lines must not keep showing the last value.
    wait_cyc(16);
  endtask
endmodule

/* sfpe_sequencer_tb.sv */
// Self-checking bench for the flash program and erase sequencer.
// Assumes sfpe_host as the far side; array requests are logged, not stored.
`timescale 1ns/1ps
module sfpe_sequencer_tb;
  import sfpe_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic enable = 1'b1; // Clock enable, dropped once to freeze a running cycle.
  sfpe_pins_s pins;
  logic io1;
  logic io1_oe_n;
  logic active;
  logic [7:0] tidx;
  sfpe_array_req_s req;
  sfpe_status_s st;
  sfpe_array_req_s reqs[$]; // Every array request seen.
  logic [7:0] rd[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 i_clock = ~i_clock;
  // Short erase times, but long enough in the sector case to send frames while busy.
  sfpe_sequencer #(.PAGE_PROGRAM_CYCLES(300), .SUBSECTOR_ERASE_CYCLES(20),
    .SECTOR_ERASE_CYCLES(2000), .BULK_ERASE_CYCLES(20)) dut (.i_clock(i_clock),
    .i_reset(i_reset), .i_enable(enable), .i_pins(pins), .i_table_byte(tidx ^ 8'h3c),
    .o_serial_io1(io1), .o_serial_io1_oe_n(io1_oe_n), .o_table_index(tidx),
    .o_array_req(req), .o_status(st), .o_active(active));
  sfpe_host host (.i_clock(i_clock), .i_io1(io1), .i_io1_oe_n(io1_oe_n), .o_pins(pins));
  always @(posedge i_clock)
  begin
    if (req.valid === 1'b1)
      reqs.push_back(req);
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic sfpe_array_req_s mk(sfpe_array_op_e op, logic [23:0] a, logic [7:0] d);
    return {1'b1, op, a, d};
  endfunction
  task automatic send(input logic [7:0] q[$], input int nq = 0, input int nrd = 0);
    host.frame(q, nq, nrd, rd);
  endtask
  // Waits a bounded time for the self-timed cycle to end.
  task automatic wait_idle();
    int n = 0;
    while (st.write_in_progress !== 1'b0 && n < 5000)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check("wip end", 1'b0, st.write_in_progress);
  endtask
  task automatic t_latch();
    check("status reset", 2'b00, st);
    send({OP_WRITE_ENABLE});
    check("wel set", 2'b01, st);
    send({OP_WRITE_DISABLE});
    check("wel clear", 2'b00, st);
    send({OP_WRITE_ENABLE});
    send({OP_WRITE_STATUS, 8'h00});
    check("status wel clear", 2'b00, st);
    send({OP_PAGE_WRITE, 8'h00, 8'h01, 8'h00, 8'haa});
    check("locked reqs", 0, reqs.size());
    check("locked wip", 2'b00, st);
  endtask
  // Three bytes from column fe wrap to column 00 of the same page.
  task automatic t_page();
    send({OP_WRITE_ENABLE});
    reqs = {};
    send({OP_PAGE_WRITE, 8'h01, 8'h02, 8'hfe, 8'ha1, 8'ha2, 8'ha3});
    check("page busy", 2'b10, st);
    wait_idle();
    check("page count", 3, reqs.size());
    check("page col 00", mk(ARR_WRITE_BYTE, 24'h010200, 8'ha3), reqs[0]);
    check("page col fe", mk(ARR_WRITE_BYTE, 24'h0102fe, 8'ha1), reqs[1]);
    check("page col ff", mk(ARR_WRITE_BYTE, 24'h0102ff, 8'ha2), reqs[2]);
  endtask
  // 257 bytes: column 0 must hold the last byte sent, not the first.
  task automatic t_over();
    logic [7:0] q[$];
    q = {OP_PAGE_WRITE, 8'h03, 8'h04, 8'h00};
    for (int i = 0; i < 257; i++)
      q.push_back(i[7:0] ^ (i > 255 ? 8'h55 : 8'h00));
    send({OP_WRITE_ENABLE});
    reqs = {};
    send(q);
    wait_idle();
    check("over count", 256, reqs.size());
    for (int c = 0; c < 256; c++)
      check("over byte", mk(ARR_WRITE_BYTE, {16'h0304, c[7:0]},
        (c == 0) ? 8'h55 : c[7:0]), reqs[c]);
  endtask
  task automatic t_quad();
    send({OP_WRITE_ENABLE});
    reqs = {};
    send({OP_QUAD_WRITE, 8'h05, 8'h06, 8'h10, 8'h5c, 8'h3e}, 2);
    wait_idle();
    check("quad count", 2, reqs.size());
    check("quad first", mk(ARR_WRITE_BYTE, 24'h050610, 8'h5c), reqs[0]);
    check("quad second", mk(ARR_WRITE_BYTE, 24'h050611, 8'h3e), reqs[1]);
  endtask
  task automatic t_erase();
    sfpe_array_op_e arr[3] = '{ARR_ERASE_ALL, ARR_ERASE_SUBSECTOR, ARR_ERASE_SECTOR};
    logic [7:0] opc[3] = '{OP_BULK_ERASE, OP_SUBSECTOR_ERASE, OP_SECTOR_ERASE};
    for (int i = 0; i < 3; i++)
    begin
      send({OP_WRITE_ENABLE});
      reqs = {};
      if (i == 0)
        send({opc[i]});
      else
        send({opc[i], 8'h12, 8'h34, 8'h56});
      check("erase wel", 1'b0, st.write_enable_latch);
      wait_idle();
      check("erase count", 1, reqs.size());
      check("erase op", {arr[i], ERASED_BYTE}, {reqs[0].op, reqs[0].data});
      if (i != 0)
        check("erase addr", 24'h123456, reqs[0].address);
    end
  endtask
  // Start at table byte ff so the second byte shows the index wrap.
  task automatic t_table();
    send({OP_TABLE_READ, 8'h00, 8'h00, 8'hff, 8'h00}, 0, 2);
    check("table first", 8'hff ^ 8'h3c, rd[0]);
    check("table second", 8'h00 ^ 8'h3c, rd[1]);
  endtask
  // Frames sent during a sector erase are ignored and leave it running.
  task automatic t_busy();
    send({OP_WRITE_ENABLE});
    send({OP_SECTOR_ERASE, 8'h00, 8'hab, 8'h00});
    check("sector busy", 2'b10, st);
    check("busy active", 1'b1, active);
    send({OP_WRITE_ENABLE});
    check("busy wel", 2'b10, st);
    send({OP_TABLE_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 1);
    check("busy read", 8'hff, rd[0]);
    check("busy kept", 1'b1, st.write_in_progress);
    // A frozen clock enable must hold the erase past its normal end.
    enable = 1'b0;
    host.wait_cyc(2100);
    enable = 1'b1;
    check("frozen wip", 1'b1, st.write_in_progress);
    wait_idle();
    host.wait_cyc(8);
    check("standby", 1'b0, active);
  endtask
  initial
  begin
    repeat (3) @(posedge i_clock);
    #1 i_reset = 1'b0;
    repeat (4) @(posedge i_clock);
    t_latch();
    // Erasing comes first so that the later page writes land on erased bytes.
    t_erase();
    t_page();
    t_over();
    t_quad();
    t_table();
    t_busy();
    results();
  end
endmodule
